// ### shared/hlt_params.svh
// Constants for the hardware-limit timer mode control
`ifndef HLT_PARAMS_SVH
`define HLT_PARAMS_SVH
// ==========================================
// Mode field layout
`define HLT_MODE_W 5
`define HLT_CNT_W 8
`define HLT_CNT_ZERO 8'h00
// Sub-mode codes (low three bits)
`define HLT_SUB_000 3'h0
`define HLT_SUB_001 3'h1
`define HLT_SUB_010 3'h2
`define HLT_SUB_011 3'h3
`define HLT_SUB_100 3'h4
`define HLT_SUB_101 3'h5
`define HLT_SUB_110 3'h6
`define HLT_SUB_111 3'h7
// Group codes (top two bits)
`define HLT_GRP_FREE 2'h0
`define HLT_GRP_ONE 2'h1
`define HLT_GRP_MONO 2'h2
`endif

// ### shared/hlt_pkg.sv
// Types shared by the hardware-limit timer mode control
package hlt_pkg;
    // ==========================================
    // Run state of the timer
    typedef enum logic [1:0] {
        HLT_IDLE = 2'b00,
        HLT_ARMED = 2'b01,
        HLT_RUN = 2'b10
    } hlt_state_t;
endpackage : hlt_pkg

// ### rtl/hlt_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module hlt_sync (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    import hlt_pkg::*;
    // ==========================================
    // Stage registers
    logic s1;
    logic s2;
    logic s3;
    // Update the filtered level only when the last two stages agree
    wire agree = (s2 == s3);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (agree) begin
                sync_out <= s3;
            end
        end
    end
endmodule : hlt_sync

// ### rtl/hlt_timer.sv
// Mode control and 8-bit counter of the hardware-limit timer
`timescale 1ns/1ps
`include "hlt_params.svh"
module hlt_timer #(
    parameter int CNT_W = `HLT_CNT_W
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [`HLT_MODE_W-1:0] mode,
    input wire logic run_set,
    input wire logic run_clear,
    input wire logic [CNT_W-1:0] period_value,
    input wire logic external_reset_source,
    output logic run_bit,
    output logic [CNT_W-1:0] count_value,
    output logic running,
    output hlt_pkg::hlt_state_t state
);
    import hlt_pkg::*;

    // ==========================================
    // Elaboration check
    if (CNT_W != `HLT_CNT_W) begin : g_bad_width
        $error("hlt_timer supports only the documented counter width");
    end

    // ==========================================
    // Input synchronisation
    logic ext;       // Filtered external level
    logic ext_q;     // Previous filtered level, for edges
    hlt_sync u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .clk_en(clk_en),
        .async_in(external_reset_source),
        .sync_out(ext)
    );

    // ==========================================
    // Mode decode
    wire [1:0] grp = mode[4:3];
    wire [2:0] sub = mode[2:0];
    wire rise = ext & ~ext_q;
    wire fall = ~ext & ext_q;
    wire any_edge = rise | fall;
    wire is_free = (grp == `HLT_GRP_FREE);
    wire is_one = (grp == `HLT_GRP_ONE);
    wire is_mono = (grp == `HLT_GRP_MONO) &&
                   ((sub == `HLT_SUB_001) || (sub == `HLT_SUB_010) || (sub == `HLT_SUB_011));
    wire is_lvl1 = (grp == `HLT_GRP_MONO) &&
                   ((sub == `HLT_SUB_110) || (sub == `HLT_SUB_111));
    // Reserved codes freeze the count and force the idle state; the run bit still follows run_set and run_clear
    wire legal = is_free | is_one | is_mono | is_lvl1;
    wire limited = is_one | is_lvl1;   // Match clears the run bit
    wire match = (count_value == period_value);

    // Edge or level that starts an armed one-shot or monostable
    logic start_evt;
    always_comb begin
        start_evt = 1'b0;
        unique case (sub)
            `HLT_SUB_000: start_evt = is_one;
            `HLT_SUB_001: start_evt = rise;
            `HLT_SUB_010: start_evt = fall;
            `HLT_SUB_011: start_evt = any_edge;
            `HLT_SUB_100: start_evt = rise;
            `HLT_SUB_101: start_evt = fall;
            `HLT_SUB_110: start_evt = is_lvl1 ? ext : rise;
            `HLT_SUB_111: start_evt = is_lvl1 ? ~ext : fall;
        endcase
    end

    // Hardware reset condition of the count
    logic hw_rst;
    always_comb begin
        hw_rst = 1'b0;
        if (is_free || is_one || is_lvl1) begin
            unique case (sub)
                `HLT_SUB_011: hw_rst = is_free & any_edge;
                `HLT_SUB_100: hw_rst = rise;
                `HLT_SUB_101: hw_rst = fall;
                `HLT_SUB_110: hw_rst = ~ext;
                `HLT_SUB_111: hw_rst = ext;
                default: hw_rst = 1'b0;
            endcase
        end
    end

    // Free-running gate: true when counting is allowed
    logic free_gate;
    always_comb begin
        free_gate = 1'b1;
        unique case (sub)
            `HLT_SUB_001: free_gate = ext;
            `HLT_SUB_010: free_gate = ~ext;
            `HLT_SUB_110: free_gate = ext;
            `HLT_SUB_111: free_gate = ~ext;
            default: free_gate = 1'b1;
        endcase
    end

    // ==========================================
    // Next-state logic
    hlt_state_t next_state;
    logic [CNT_W-1:0] next_count;
    logic next_run_bit;
    always_comb begin
        next_state = state;
        next_count = count_value;
        next_run_bit = run_bit;
        if (run_set) begin
            next_run_bit = 1'b1;
        end
        if (run_clear) begin
            next_run_bit = 1'b0;
        end
        if (!legal) begin
            next_state = HLT_IDLE;
        end else if (!run_bit) begin
            // Edges seen while off are dropped: the arm step waits for a fresh one
            next_state = HLT_IDLE;
        end else if (is_free) begin
            next_state = HLT_RUN;
            if (hw_rst) begin
                next_count = `HLT_CNT_ZERO;
            end else if (free_gate) begin
                next_count = CNT_W'(count_value + 1'b1);
            end
        end else if (state == HLT_IDLE) begin
            // Run bit newly set: arm, ignore events of this cycle
            next_state = HLT_ARMED;
            next_count = `HLT_CNT_ZERO;
        end else if (state == HLT_ARMED) begin
            if (start_evt) begin
                next_state = HLT_RUN;
            end
        end else begin
            if (hw_rst) begin
                next_count = `HLT_CNT_ZERO;
                if (is_lvl1 || sub == `HLT_SUB_110 || sub == `HLT_SUB_111) begin
                    next_state = is_lvl1 ? HLT_ARMED : HLT_RUN;
                end
            end else if (match) begin
                next_count = `HLT_CNT_ZERO;
                next_state = HLT_ARMED;
                if (limited) begin
                    // Software set beats the hardware clear, a software clear beats both
                    next_run_bit = run_set & ~run_clear;
                    next_state = HLT_IDLE;
                end
            end else begin
                next_count = CNT_W'(count_value + 1'b1);
            end
        end
    end

    // Counting indication for the surrounding logic
    assign running = (state == HLT_RUN) && run_bit &&
                     (!is_free || (free_gate && !hw_rst));

    // ==========================================
    // State registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= HLT_IDLE;
            count_value <= `HLT_CNT_ZERO;
            run_bit <= 1'b0;
            ext_q <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            count_value <= next_count;
            run_bit <= next_run_bit;
            ext_q <= ext;
        end
    end

    // ==========================================
    // Assertions
    sequence s_one_match;
        run_bit && is_one && state == HLT_RUN && match && !hw_rst && !run_set && clk_en;
    endsequence
    a_one_shot_end: assert property (@(posedge sys_clk) disable iff (srst)
        s_one_match |=> !run_bit && count_value == `HLT_CNT_ZERO)
        else $error("one-shot did not stop at zero");
    a_mono_keeps_run: assert property (@(posedge sys_clk) disable iff (srst)
        (run_bit && is_mono && state == HLT_RUN && match && !run_clear && clk_en)
        |=> run_bit && count_value == `HLT_CNT_ZERO && state == HLT_ARMED)
        else $error("monostable lost run bit");
    a_reserved_hold: assert property (@(posedge sys_clk) disable iff (srst)
        (!legal && clk_en && $stable(mode)) |=> $stable(count_value))
        else $error("count moved in reserved mode");
    a_soft_gate: assert property (@(posedge sys_clk) disable iff (srst)
        (mode == 5'h00 && run_bit && state == HLT_RUN && clk_en)
        |=> count_value == $past(count_value) + 8'h01)
        else $error("software gate did not count");
    a_hw_gate_off: assert property (@(posedge sys_clk) disable iff (srst)
        (mode == 5'h01 && !ext && clk_en) |=> $stable(count_value))
        else $error("gated timer counted");
    a_edge_reset: assert property (@(posedge sys_clk) disable iff (srst)
        (mode == 5'h04 && run_bit && rise && clk_en) |=> count_value == `HLT_CNT_ZERO)
        else $error("rising edge did not reset");
    a_level_reset: assert property (@(posedge sys_clk) disable iff (srst)
        (mode == 5'h06 && run_bit && !ext && clk_en) |=> count_value == `HLT_CNT_ZERO)
        else $error("low level did not hold reset");
    a_no_stale_start: assert property (@(posedge sys_clk) disable iff (srst)
        (!run_bit && !is_free && clk_en) |=> state != HLT_RUN)
        else $error("started without fresh edge");
endmodule : hlt_timer

// ### dv/hlt_ext_src.sv
// Behavioural source of the external start, gate and reset level
`timescale 1ns/1ps
module hlt_ext_src (
    output logic ext_sig,
    input wire logic sys_clk
);
    // ==========================================
    // Level driver
    // Each change is held 8 cycles so the input filter has settled
    initial ext_sig = 1'h0;
    task automatic put(input logic lvl);
        @(negedge sys_clk);
        ext_sig = lvl;
        repeat (8) @(negedge sys_clk);
    endtask : put
endmodule : hlt_ext_src

// ### dv/testbench.sv
// Self-checking bench for the hardware-limit timer mode control
`timescale 1ns/1ps
`include "hlt_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
    import hlt_pkg::*;
    // ==========================================
    // Signals and score
    logic sys_clk, srst, clk_en, run_set, run_clear, ext, run_bit, running;
    logic [`HLT_MODE_W-1:0] mode;
    logic [`HLT_CNT_W-1:0] period_value, count_value, c, peak;
    hlt_state_t state;
    int fails = 0;
    int n_checks = 0;
    int shots[7] = '{8, 9, 10, 11, 17, 18, 19};
    int lvls[6] = '{6, 7, 14, 15, 22, 23};
    hlt_timer dut_u (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .mode(mode),
        .run_set(run_set), .run_clear(run_clear), .period_value(period_value),
        .external_reset_source(ext), .run_bit(run_bit), .count_value(count_value),
        .running(running), .state(state));
    hlt_ext_src ext_u (.ext_sig(ext), .sys_clk(sys_clk));
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Highest count since reset; the shot loop waits for it to reach the period and the count to fall back to zero
    always @(posedge sys_clk) begin
        peak <= srst ? `HLT_CNT_ZERO : (count_value > peak ? count_value : peak);
    end
    // ==========================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic set_run();
        run_set = 1'h1;
        tick(1);
        run_set = 1'h0;
        tick(2);
    endtask : set_run
    task automatic clr_run();
        run_clear = 1'h1;
        tick(1);
        run_clear = 1'h0;
        tick(2);
    endtask : clr_run
    // Reset, load mode and period, park the external level, maybe start
    task automatic start(input int m, input logic [7:0] p, input logic lvl, input logic go);
        srst = 1'h1;
        mode = 5'(m);
        period_value = p;
        ext_u.put(lvl);
        srst = 1'h0;
        // Let the pin filter catch up with the parked level so its edge out of reset passes before the run bit is set
        tick(5);
        if (go) set_run();
    endtask : start
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // ==========================================
    // Scenarios
    task automatic t_gates();
        for (int m = 0; m < 3; m++) begin
            start(m, 8'hFF, m != 2, 1'h1);
            tick(4);
            c = count_value;
            tick(6);
            `CHK(count_value, c + 8'h06)
            `CHK(running, 1'h1)
            ext_u.put(m == 2);
            c = count_value;
            tick(4);
            `CHK(count_value, (m == 0) ? c + 8'h04 : c)
            `CHK(running, m == 0)
            clr_run();
            c = count_value;
            tick(3);
            `CHK(count_value, c)
            `CHK(running, 1'h0)
        end
        $display("test gates done");
    endtask : t_gates
    task automatic t_edges();
        for (int m = 3; m < 6; m++) begin
            start(m, 8'hFF, 1'h0, 1'h1);
            tick(20);
            ext_u.put(1'h1);
            `CHK(count_value < 8'h0A, m != 5)
            tick(20);
            ext_u.put(1'h0);
            `CHK(count_value < 8'h0A, m != 4)
        end
        $display("test edges done");
    endtask : t_edges
    // Low bit of the mode picks the level that holds the count in reset
    task automatic t_level(input int m);
        start(m, 8'hFF, m[0], 1'h1);
        tick(6);
        `CHK(count_value, 8'h00)
        ext_u.put(!m[0]);
        tick(4);
        `CHK(count_value != 8'h00, 1'h1)
        ext_u.put(m[0]);
        `CHK(count_value, 8'h00)
        ext_u.put(!m[0]);
        clr_run();
        c = count_value;
        tick(4);
        `CHK(count_value, c)
        $display("test level %0d done", m);
    endtask : t_level
    task automatic t_shot(input int m);
        int i;
        start(m, 8'h05, 1'h0, m == 8);
        if (m != 8) begin
            ext_u.put(1'h1);
            ext_u.put(1'h0);
            set_run();
            tick(6);
            `CHK(peak, 8'h00)
            ext_u.put(1'h1);
            if (m[1:0] == 2) begin
                `CHK(peak, 8'h00)
                ext_u.put(1'h0);
            end
        end
        i = 0;
        while (!(peak === 8'h05 && count_value === 8'h00)) begin
            i++;
            if (i > 40) begin
                fails++;
                give_verdict();
            end else tick(1);
        end
        `CHK(run_bit, m >= 16)
        `CHK(state, (m >= 16) ? HLT_ARMED : HLT_IDLE)
        tick(3);
        `CHK(count_value, 8'h00)
        $display("test shot %0d done", m);
    endtask : t_shot
    // Opposite edge leaves the count, same-polarity edge restarts it
    task automatic t_restart(input int m);
        start(m, 8'h28, m != 12, 1'h1);
        tick(3);
        ext_u.put(m == 12);
        ext_u.put(m != 12);
        `CHK(count_value > 8'h0A, 1'h1)
        ext_u.put(m == 12);
        `CHK(count_value < 8'h0A, 1'h1)
        $display("test restart %0d done", m);
    endtask : t_restart
    // Enable low freezes count and run bit; a clear pulse meanwhile is lost
    task automatic t_freeze();
        start(0, 8'hFF, 1'h0, 1'h1);
        clk_en = 1'h0;
        c = count_value;
        tick(2);
        run_clear = 1'h1;
        tick(1);
        run_clear = 1'h0;
        tick(2);
        `CHK(count_value, c)
        `CHK(run_bit, 1'h1)
        clk_en = 1'h1;
        tick(3);
        `CHK(count_value, c + 8'h03)
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_reserved();
        start(0, 8'hFF, 1'h0, 1'h1);
        for (int r = 16; r < 32; r++) begin
            if (r inside {17, 18, 19, 22, 23}) continue;
            mode = 5'h00;
            tick(3);
            mode = 5'(r);
            tick(2);
            c = count_value;
            tick(4);
            `CHK(count_value, c)
        end
        $display("test reserved done");
    endtask : t_reserved
    // ==========================================
    // Main sequence
    initial begin
        srst = 1'h1;
        clk_en = 1'h1;
        run_set = 1'h0;
        run_clear = 1'h0;
        mode = 5'h00;
        period_value = 8'hFF;
        tick(5);
        srst = 1'h0;
        tick(1);
        t_gates();
        t_freeze();
        t_edges();
        foreach (lvls[i]) t_level(lvls[i]);
        foreach (shots[i]) t_shot(shots[i]);
        t_restart(12);
        t_restart(13);
        t_reserved();
        give_verdict();
    end
endmodule : testbench
